/* rtl/flash_link_pkg.sv */
// Constants, state codes and carrier structs for the programming-mode link block.
// Assumes a single 50 MHz clock and an APB master that owns the register side.
package flash_link_pkg;

    // Timing.
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned INIT_BAUD = 9600;
    localparam int unsigned INIT_BIT_CYCLES = CLK_HZ / INIT_BAUD;
    localparam logic [15:0] DIV_MIN = 16'h0004;

    // Character format.
    localparam logic [7:0] READY_BYTE = 8'h00;
    localparam logic [7:0] LOW_BYTE = 8'h00;
    localparam logic [3:0] TX_FRAME_BITS = 4'ha;
    localparam logic [3:0] RX_FRAME_BITS = 4'hb;
    localparam logic [3:0] RX_LAST_DATA = 4'h3;

    // Register byte offsets.
    localparam logic [11:0] ADDR_STATUS = 12'h000;
    localparam logic [11:0] ADDR_RXDATA = 12'h004;
    localparam logic [11:0] ADDR_TXDATA = 12'h008;
    localparam logic [11:0] ADDR_BAUD = 12'h00c;
    localparam logic [11:0] ADDR_BAUD_ACT = 12'h010;

    // Status field positions.
    localparam int ST_PROG = 0;
    localparam int ST_READY_SENT = 1;
    localparam int ST_LOW_SEEN = 2;
    localparam int ST_RX_VALID = 3;
    localparam int ST_TX_BUSY = 4;
    localparam int ST_FRAME_ERR = 5;
    localparam int ST_OVERRUN = 6;
    localparam int ST_BAUD_PEND = 7;
    localparam int ST_LINK_UP = 8;

    typedef enum logic [5:0] {
        st_boot = 6'b000001,
        st_normal = 6'b000010,
        st_ready = 6'b000100,
        st_ready_wait = 6'b001000,
        st_wait_low = 6'b010000,
        st_link = 6'b100000
    } seq_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_s;

    typedef struct packed {
        logic busy;
        logic [3:0] bits;
        logic [15:0] cnt;
        logic [9:0] shift;
    } tx_s;

    typedef struct packed {
        logic busy;
        logic [3:0] bits;
        logic [15:0] cnt;
        logic [7:0] shift;
        logic err;
    } rx_s;

endpackage

/* rtl/flash_link.sv */
// Device end of the single-wire programming link, with an APB register slave.
// Assumes the data pin is resolved outside from data_out and data_oe_n,
// and that presetn is the device system reset driven by the programmer.
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
module flash_link #(
    parameter int INIT_BIT_CYCLES = flash_link_pkg::INIT_BIT_CYCLES
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Register bus.
    input wire flash_link_pkg::apb_req_s apb_req,
    output flash_link_pkg::apb_rsp_s apb_rsp,
    // Mode strap.
    input wire logic mode_select_pin,
    // Single-wire data pin, split into its three signals.
    input wire logic single_wire_data_pin_in,
    output logic single_wire_data_pin_out,
    output logic single_wire_data_pin_oe_n,
    // Operating mode for the rest of the chip.
    output logic prog_mode
);
    import flash_link_pkg::*;

    localparam logic [15:0] DIV_RESET = 16'(INIT_BIT_CYCLES);

    seq_e state, next_state;
    tx_s tx, next_tx;
    rx_s rx, next_rx;
    logic next_prog_mode;
    logic ready_sent, next_ready_sent;
    logic low_seen, next_low_seen;
    logic [15:0] baud_act, next_baud_act;
    logic [15:0] baud_pend, next_baud_pend;
    logic pend_flag, next_pend_flag;
    logic rx_valid, next_rx_valid;
    logic [7:0] rx_data, next_rx_data;
    logic frame_err, next_frame_err;
    logic overrun, next_overrun;
    logic [31:0] prdata, next_prdata;
    logic tx_go;
    logic [7:0] tx_byte;
    logic tx_done;
    logic rx_enable;
    logic rx_done;
    logic setup;
    logic access;
    logic mapped;
    logic wr_tx;
    logic wr_baud;
    logic rd_rx;
    logic [31:0] status_word;

    // Bus phase decode; the slave answers every access with no wait state.
    assign setup = apb_req.psel && !apb_req.penable;
    assign access = apb_req.psel && apb_req.penable;
    assign mapped = (apb_req.paddr == ADDR_STATUS) || (apb_req.paddr == ADDR_RXDATA)
        || (apb_req.paddr == ADDR_TXDATA) || (apb_req.paddr == ADDR_BAUD)
        || (apb_req.paddr == ADDR_BAUD_ACT);
    assign wr_tx = access && apb_req.pwrite && (apb_req.paddr == ADDR_TXDATA);
    assign wr_baud = access && apb_req.pwrite && (apb_req.paddr == ADDR_BAUD);
    assign rd_rx = access && !apb_req.pwrite && (apb_req.paddr == ADDR_RXDATA);
    assign apb_rsp = '{prdata: prdata,
        pready: 1'b1,
        pslverr: access && !mapped};

    // Pin drive: released whenever no character is going out.
    assign single_wire_data_pin_out = tx.busy ? tx.shift[0] : 1'b1;
    assign single_wire_data_pin_oe_n = !tx.busy;

    // Session sequencer: strap capture, ready byte, wait for the low byte, link.
    always_comb
    begin
        next_state = state;
        next_prog_mode = prog_mode;
        next_ready_sent = ready_sent;
        next_low_seen = low_seen;
        tx_go = 1'b0;
        tx_byte = READY_BYTE;
        rx_enable = 1'b0;
        unique case (state)
            st_boot:
            begin
                // The strap is caught by this clocked step, never by the reset itself.
                next_prog_mode = mode_select_pin;
                next_state = mode_select_pin ? st_ready : st_normal;
            end
            st_normal: next_state = st_normal; // Only a reset leaves normal mode.
            st_ready:
            begin
                tx_go = 1'b1;
                tx_byte = READY_BYTE;
                next_state = st_ready_wait;
            end
            st_ready_wait:
            begin
                if (tx_done)
                begin
                    next_ready_sent = 1'b1;
                    next_state = st_wait_low;
                end
            end
            st_wait_low:
            begin
                rx_enable = 1'b1;
                if (rx_done)
                begin
                    // A wrong or broken low byte still opens the link; software sees why.
                    // The second stop bit is sampled in this very cycle, so look at the pin.
                    next_low_seen = (rx.shift == LOW_BYTE) && !rx.err
                        && single_wire_data_pin_in;
                    next_state = st_link;
                end
            end
            st_link:
            begin
                // Half duplex: the receiver sleeps while our own character is out.
                rx_enable = !tx.busy;
                tx_go = wr_tx && !tx.busy;
                tx_byte = apb_req.pwdata[7:0];
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= st_boot;
            prog_mode <= 1'b0;
            ready_sent <= 1'b0;
            low_seen <= 1'b0;
        end
        else
        begin
            state <= next_state;
            prog_mode <= next_prog_mode;
            ready_sent <= next_ready_sent;
            low_seen <= next_low_seen;
        end
    end

    // Transmitter: start bit, 8 data bits LSB first, one stop bit, no parity.
    always_comb
    begin
        next_tx = tx;
        tx_done = 1'b0;
        if (!tx.busy)
        begin
            if (tx_go)
            begin
                next_tx.busy = 1'b1;
                next_tx.bits = TX_FRAME_BITS;
                next_tx.shift = {1'b1, tx_byte, 1'b0};
                next_tx.cnt = baud_act - 16'h0001;
            end
        end
        else if (tx.cnt != 16'h0000)
        begin
            next_tx.cnt = tx.cnt - 16'h0001;
        end
        else if (tx.bits == 4'h1)
        begin
            next_tx.busy = 1'b0;
            tx_done = 1'b1;
        end
        else
        begin
            next_tx.bits = tx.bits - 4'h1;
            next_tx.shift = {1'b1, tx.shift[9:1]};
            next_tx.cnt = baud_act - 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx <= '{busy: 1'b0, bits: 4'h0, cnt: 16'h0000, shift: 10'h3ff};
        end
        else
        begin
            tx <= next_tx;
        end
    end

    // Receiver: samples mid-bit, expects two stop bits from the programmer.
    // A low stop bit marks a framing error but the byte is still delivered.
    always_comb
    begin
        next_rx = rx;
        rx_done = 1'b0;
        if (!rx.busy)
        begin
            if (rx_enable && !single_wire_data_pin_in)
            begin
                next_rx.busy = 1'b1;
                next_rx.bits = RX_FRAME_BITS;
                next_rx.cnt = {1'b0, baud_act[15:1]};
                next_rx.err = 1'b0;
            end
        end
        else if (rx.cnt != 16'h0000)
        begin
            next_rx.cnt = rx.cnt - 16'h0001;
        end
        else
        begin
            next_rx.cnt = baud_act - 16'h0001;
            next_rx.bits = rx.bits - 4'h1;
            if (rx.bits == RX_FRAME_BITS)
            begin
                // A start bit that did not last to mid-bit was a glitch.
                next_rx.busy = !single_wire_data_pin_in;
            end
            else if (rx.bits >= RX_LAST_DATA)
            begin
                next_rx.shift = {single_wire_data_pin_in, rx.shift[7:1]};
            end
            else
            begin
                if (!single_wire_data_pin_in)
                begin
                    next_rx.err = 1'b1;
                end
                if (rx.bits == 4'h1)
                begin
                    next_rx.busy = 1'b0;
                    rx_done = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx <= '{busy: 1'b0, bits: 4'h0, cnt: 16'h0000, shift: 8'h00, err: 1'b0};
        end
        else
        begin
            rx <= next_rx;
        end
    end

    // Status word seen by software.
    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[ST_PROG] = prog_mode;
        status_word[ST_READY_SENT] = ready_sent;
        status_word[ST_LOW_SEEN] = low_seen;
        status_word[ST_RX_VALID] = rx_valid;
        status_word[ST_TX_BUSY] = tx.busy;
        status_word[ST_FRAME_ERR] = frame_err;
        status_word[ST_OVERRUN] = overrun;
        status_word[ST_BAUD_PEND] = pend_flag;
        status_word[ST_LINK_UP] = (state == st_link);
    end

    // Register file. A new rate is held pending and only applied once the
    // character in flight (the acknowledge) has left, so the next character
    // in either direction, the sync command, uses the new rate.
    always_comb
    begin
        next_baud_act = baud_act;
        next_baud_pend = baud_pend;
        next_pend_flag = pend_flag;
        next_rx_valid = rx_valid;
        next_rx_data = rx_data;
        next_frame_err = frame_err;
        next_overrun = overrun;
        next_prdata = prdata;
        if (pend_flag && tx_done)
        begin
            next_baud_act = baud_pend;
            next_pend_flag = 1'b0;
        end
        if (wr_baud && (apb_req.pwdata[15:0] >= DIV_MIN))
        begin
            next_baud_pend = apb_req.pwdata[15:0];
            next_pend_flag = 1'b1;
        end
        if (rd_rx)
        begin
            next_rx_valid = 1'b0;
            next_frame_err = 1'b0;
            next_overrun = 1'b0;
        end
        // A byte landing in the same cycle as the read-clear wins.
        if (rx_done && (state == st_link))
        begin
            next_rx_valid = 1'b1;
            next_rx_data = rx.shift;
            next_frame_err = rx.err || !single_wire_data_pin_in;
            next_overrun = rx_valid && !rd_rx;
        end
        if (setup)
        begin
            unique case (apb_req.paddr)
                ADDR_STATUS: next_prdata = status_word;
                ADDR_RXDATA: next_prdata = {24'h000000, rx_data};
                ADDR_BAUD: next_prdata = {16'h0000, baud_pend};
                ADDR_BAUD_ACT: next_prdata = {16'h0000, baud_act};
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            baud_act <= DIV_RESET;
            baud_pend <= DIV_RESET;
            pend_flag <= 1'b0;
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            frame_err <= 1'b0;
            overrun <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            baud_act <= next_baud_act;
            baud_pend <= next_baud_pend;
            pend_flag <= next_pend_flag;
            rx_valid <= next_rx_valid;
            rx_data <= next_rx_data;
            frame_err <= next_frame_err;
            overrun <= next_overrun;
            prdata <= next_prdata;
        end
    end

endmodule

/* verif/flash_link_checker.sv */
// Concurrent checks on the ports of the programming-mode link block.
// Assumes one clock, pclk, and the active-low asynchronous reset presetn.
`timescale 1ns/10ps
module flash_link_checker #(
    parameter int INIT_BIT_CYCLES = flash_link_pkg::INIT_BIT_CYCLES
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Register bus.
    input wire flash_link_pkg::apb_req_s apb_req,
    input wire flash_link_pkg::apb_rsp_s apb_rsp,
    // Strap, data line and mode.
    input wire logic mode_select_pin,
    input wire logic single_wire_data_pin_in,
    input wire logic single_wire_data_pin_out,
    input wire logic single_wire_data_pin_oe_n,
    input wire logic prog_mode
);
    import flash_link_pkg::*;
    wire oe_n = single_wire_data_pin_oe_n;
    wire out = single_wire_data_pin_out;
    logic [15:0] len;
    logic [15:0] next_len;
    logic first;
    logic next_first;

    // Cycles the device has driven the line; the first frame after reset is the ready byte.
    always_comb
    begin
        next_len = oe_n ? 16'h0000 : len + 16'h0001;
        next_first = first && !(oe_n && len != 16'h0000);
    end

    // Registers only; len cleared and first set by reset, so the first frame of every session is checked as the ready frame.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            len <= 16'h0000;
            first <= 1'b1;
        end
        else
        begin
            len <= next_len;
            first <= next_first;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_normal_quiet: assert property (!prog_mode |-> oe_n)
        else $error("line driven outside programming mode");
    a_mode_held: assert property (
        $past(presetn) && $past(presetn, 2) && $past(presetn, 3) |-> $stable(prog_mode))
        else $error("mode changed after entry");
    a_ready_soon: assert property ($rose(prog_mode) |-> ##[0:2] !oe_n)
        else $error("ready byte not started");
    a_start_low: assert property ($fell(oe_n) |-> !out)
        else $error("start bit not low");
    a_ready_zero: assert property (
        first && !oe_n && len < 9 * INIT_BIT_CYCLES - 1 |-> !out)
        else $error("ready byte not zero");
    a_ready_len: assert property ($rose(oe_n) && first |->
        len >= 10 * INIT_BIT_CYCLES - 1 && len <= 10 * INIT_BIT_CYCLES + 1)
        else $error("ready frame length wrong");
    a_one_stop: assert property ($rose(oe_n) |-> $past(out) && $past(out, 2))
        else $error("stop bit missing");
    a_idle_high: assert property (oe_n |-> out)
        else $error("released output not high");

    c_frame_done: cover property ($rose(oe_n));
    c_prog_entry: cover property ($rose(prog_mode));
    c_bus_error: cover property (apb_rsp.pslverr);
endmodule

bind flash_link flash_link_checker #(.INIT_BIT_CYCLES(INIT_BIT_CYCLES)) i_checker (
    .pclk, .presetn, .apb_req, .apb_rsp, .mode_select_pin, .single_wire_data_pin_in,
    .single_wire_data_pin_out, .single_wire_data_pin_oe_n, .prog_mode
);

/* verif/prog_model.sv */
// Behavioural programmer at the far end of the single-wire link.
// Assumes a pull-up on the line and a bit time given in pclk cycles.
`timescale 1ns/10ps
module prog_model (
    // Clock.
    input wire logic pclk,
    // Resolved line and bit time.
    input wire logic line,
    input wire logic [15:0] bit_cycles,
    // Line driver, enable active low.
    output logic p_out,
    output logic p_oe_n,
    // Character received from the device, with its stop bit.
    output logic [7:0] rx_byte,
    output logic rx_stop,
    output logic rx_stb
);
    logic [7:0] data;

    // Start released, so the device can send its ready byte.
    initial
    begin
        p_out = 1'b0;
        p_oe_n = 1'b1;
        rx_byte = 8'h00;
        rx_stop = 1'b0;
        rx_stb = 1'b0;
    end

    // Start bit, data LSB first, two stop bits, then let go of the line.
    task automatic send_char(input logic [7:0] b);
        logic [10:0] frame;
        frame = {2'b11, b, 1'b0};
        for (int k = 0; k < 11; k++)
        begin
            p_out <= frame[k];
            p_oe_n <= 1'b0;
            repeat (bit_cycles) @(posedge pclk);
        end
        p_oe_n <= 1'b1;
        p_out <= 1'b0;
    endtask

    // Sample mid-bit after a falling edge; own transmissions are not listened to.
    always @(posedge pclk)
    begin
        rx_stb <= 1'b0;
        if (p_oe_n && line === 1'b0)
        begin
            repeat (bit_cycles / 2) @(posedge pclk);
            for (int k = 0; k < 8; k++)
            begin
                repeat (bit_cycles) @(posedge pclk);
                data[k] = line;
            end
            repeat (bit_cycles) @(posedge pclk);
            rx_stop <= line;
            rx_byte <= data;
            rx_stb <= 1'b1;
        end
    end
endmodule

/* verif/flash_link_tb.sv */
// Self-checking bench for the programming-mode link block.
// Assumes the programmer model and the bound checker; pull-up on the data line.
`timescale 1ns/10ps
module flash_link_tb;
    import flash_link_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic mode_select_pin = 1'b0;
    apb_req_s apb_req = '0;
    apb_rsp_s apb_rsp;
    logic dev_out, dev_oe_n, prog_mode, line, p_out, p_oe_n, rx_stb, rx_stop;
    logic [7:0] rx_byte;
    logic [15:0] pbits = 16'h0010;
    logic [32:0] exp_rd[$];
    logic [8:0] exp_rx[$];
    logic [31:0] seed = 32'heada;
    int err_count = 0;
    int n_tests = 0;

    // Clock, and a wired-and line: low while either side drives a zero.
    always #10 pclk = ~pclk;
    assign line = (dev_oe_n ? 1'b1 : dev_out) & (p_oe_n ? 1'b1 : p_out);

    flash_link #(.INIT_BIT_CYCLES(16)) i_dut (
        .pclk, .presetn, .apb_req, .apb_rsp, .mode_select_pin,
        .single_wire_data_pin_in(line), .single_wire_data_pin_out(dev_out),
        .single_wire_data_pin_oe_n(dev_oe_n), .prog_mode
    );
    prog_model i_prog (
        .pclk, .line, .bit_cycles(pbits), .p_out, .p_oe_n, .rx_byte, .rx_stop, .rx_stb
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic give_up();
        err_count++;
        give_verdict();
    endtask

    task automatic check_read(input logic [32:0] exp, input logic [32:0] got);
        n_tests++;
        if (got !== exp) err_count++;
        if (got !== exp) $display("wrong value read: expected %h, seen %h", exp, got);
    endtask

    task automatic check_char(input logic [8:0] exp, input logic [8:0] got);
        n_tests++;
        if (got !== exp) err_count++;
        if (got !== exp) $display("wrong value char: expected %h, seen %h", exp, got);
    endtask

    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        apb_req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        @(posedge pclk);
        while (apb_rsp.pready !== 1'b1 && n < 50)
        begin
            @(posedge pclk);
            n++;
        end
        if (n == 50) give_up();
        apb_req <= '0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_rd.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    // Waits until every expected character arrived and the device let go.
    task automatic wait_rx();
        int n;
        n = 0;
        while ((exp_rx.size() != 0 || dev_oe_n !== 1'b1) && n < 5000)
        begin
            @(posedge pclk);
            n++;
        end
        if (n == 5000) give_up();
    endtask

    // One random character each way at the current rate.
    task automatic exchange();
        seed = xs(seed);
        i_prog.send_char(seed[7:0]);
        rd(ADDR_RXDATA, {25'h0, seed[7:0]});
        exp_rx.push_back({1'b1, seed[15:8]});
        apb(1'b1, ADDR_TXDATA, {24'h0, seed[15:8]});
        wait_rx();
    endtask

    // Each result is compared with the oldest note of its kind.
    always @(posedge pclk)
    begin
        if (apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_rsp.pready === 1'b1)
            check_read(exp_rd.size() ? exp_rd.pop_front() : 'x,
                {apb_rsp.pslverr, apb_rsp.prdata});
        if (rx_stb === 1'b1)
            check_char(exp_rx.size() ? exp_rx.pop_front() : 'x, {rx_stop, rx_byte});
    end

    // A hang anywhere ends the run through the same report.
    initial
    begin
        repeat (100000) @(posedge pclk);
        give_up();
    end

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (40) @(posedge pclk);
        rd(ADDR_STATUS, 33'h0);
        presetn <= 1'b0;
        mode_select_pin <= 1'b1;
        exp_rx.push_back(9'h100);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        wait_rx();
        i_prog.send_char(LOW_BYTE);
        rd(ADDR_STATUS, 33'h107);
        rd(ADDR_BAUD, 33'h10);
        rd(12'h014, 33'h100000000);
        apb(1'b1, ADDR_BAUD, 32'h3);
        rd(ADDR_BAUD, 33'h10);
        repeat (3) exchange();
        apb(1'b1, ADDR_BAUD, 32'h8);
        rd(ADDR_STATUS, 33'h187);
        rd(ADDR_BAUD_ACT, 33'h10);
        exp_rx.push_back(9'h1a5);
        apb(1'b1, ADDR_TXDATA, 32'ha5);
        wait_rx();
        pbits <= 16'h0008;
        rd(ADDR_BAUD_ACT, 33'h8);
        repeat (3) exchange();
        // Two characters with no read between them: the second one overruns.
        seed = xs(seed);
        i_prog.send_char(seed[7:0]);
        @(posedge pclk);
        i_prog.send_char(seed[15:8]);
        rd(ADDR_STATUS, 33'h14f);
        rd(ADDR_RXDATA, {25'h0, seed[15:8]});
        // The device is idle and the programmer has let go before reset.
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        give_verdict();
    end
endmodule
